// ### src/lbm_be_fix.sv
/*
 * Byte lane select cleanup: widens any set of lanes into one
 * contiguous run from the lowest to the highest selected lane.
 * Pure combinational; assumes active-high lane bits at its input.
 */
`timescale 1ns/1ps
`default_nettype none

module lbm_be_fix (
	input  wire logic [3:0] lanes_i,
	output logic      [3:0] lanes_o
);

	logic [3:0] above;
	logic [3:0] below;

	// A lane is kept when some lane at or below and some at or above it is set.
	always_comb begin
		above = 4'h0;
		below = 4'h0;
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) begin
				if (j <= i && lanes_i[j]) below[i] = 1'b1;
				if (j >= i && lanes_i[j]) above[i] = 1'b1;
			end
		end
		lanes_o = above & below;
		// An empty set becomes a full word access.
		if (lanes_i == 4'h0) begin
			lanes_o = 4'hF;
		end
	end

endmodule

`default_nettype wire

// ### src/lbm_pkg.sv
/*
 * Shared definitions for the local bus master sequencer: bus states,
 * word count codes, field positions, reset values and timing counts.
 * Assumes nothing beyond a SystemVerilog compiler that accepts packages.
 */
package lbm_pkg;

	// Bus sequencer states, binary coded.
	typedef enum logic [2:0] {
		LBM_IDLE    = 3'h0,
		LBM_ADDR    = 3'h1,
		LBM_DATA    = 3'h2,
		LBM_WAIT    = 3'h3,
		LBM_RECOVER = 3'h4
	} lbm_state_t;

	// Word count codes carried on the two low shared lines.
	localparam logic [1:0] LBM_SIZE_1W = 2'h0;
	localparam logic [1:0] LBM_SIZE_2W = 2'h1;
	localparam logic [1:0] LBM_SIZE_3W = 2'h2;
	localparam logic [1:0] LBM_SIZE_4W = 2'h3;

	// Bus widths and field positions.
	localparam int LBM_DATA_W    = 32;
	localparam int LBM_LANES     = 4;
	localparam int LBM_WORDS     = 4;
	localparam int LBM_WADDR_W   = 30;
	localparam int LBM_SIZE_LSB  = 0;
	localparam int LBM_WADDR_LSB = 2;
	localparam int LBM_SYNC_W    = 34;

	// Recovery state lasts this many clocks; one state per clock.
	localparam int LBM_RECOVER_CLKS = 1;

	// Reset and idle levels of the bus controls.
	localparam logic [3:0]  LBM_BE_IDLE  = 4'hF;
	localparam logic [31:0] LBM_LAD_RST  = 32'h0000_0000;
	localparam logic [1:0]  LBM_CNT_RST  = 2'h0;

	// Complete state of the sequencer.
	typedef struct packed {
		lbm_state_t  state;
		logic        granted;
		logic        req_ready;
		logic        write;
		logic [1:0]  remain;
		logic [1:0]  idx;
		logic [127:0] wdata;
		logic [15:0] be_words;
		logic [31:0] lad_out;
		logic        lad_oe_n;
		logic        ale_n;
		logic        ads_n;
		logic        dtr;
		logic        den_n;
		logic        wr;
		logic [3:0]  be_n;
		logic [31:0] rdata;
		logic        rdata_valid;
		logic        done;
		logic        ready_seen;
	} lbm_regs_t;

	localparam lbm_regs_t LBM_REGS_RST = '{
		state: LBM_IDLE, granted: 1'b0, req_ready: 1'b0, write: 1'b0,
		remain: LBM_CNT_RST, idx: LBM_CNT_RST, wdata: '0, be_words: '0,
		lad_out: LBM_LAD_RST, lad_oe_n: 1'b1, ale_n: 1'b1, ads_n: 1'b1,
		dtr: 1'b0, den_n: 1'b1, wr: 1'b0, be_n: LBM_BE_IDLE,
		rdata: LBM_LAD_RST, rdata_valid: 1'b0, done: 1'b0, ready_seen: 1'b0
	};

endpackage

// ### src/lbm_sequencer.sv
/*
 * Device-side sequencer for a 32-bit multiplexed local bus. It takes
 * burst requests of one to four words from the core, runs them through
 * idle, address, data, wait and recovery states, and hands the bus to
 * an external master on a hold request.
 * Assumes a single 20 MHz clock, an active-low asynchronous reset, and a
 * memory or I/O controller outside that demultiplexes the bus and paces
 * every word with the active-low ready input.
 */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Address and data share one set of lines, by bus state.
// - Address state carries the word address on lines thirty-one down to two.
// - Address state carries the word count on the two low lines.
// - Count code: 00 one, 01 two, 10 three, 11 four words.
// - Exactly five states; idle when nothing is in progress.
// - A new request in idle moves to the address state.
// - After address: data if ready, else wait until ready.
// - Any number of wait states is accepted.
// - Burst words follow through data again, or wait when not ready.
// - After the last word the sequencer passes through recovery.
// - After recovery: idle, or straight into a pending request.
// - At most four words per burst, one word every four clocks best case.
// - No burst crosses an aligned sixteen-byte block.
// - Four byte lane selects mark the valid bytes of each word.
// - Byte, half and word transfers; peripherals are memory mapped. Lane cleanup also gives three-byte runs, e.g. lanes 0 to 2.
// - Sequencer drives latch, status, command, direction, transceiver enable.
// - Shared lines are released when no address or data is driven.
// - A hold request is answered with a takeover grant.
// - Status strobe in each address state and after each ready but the last in a burst.
// - Transceiver enable is low throughout data and wait states.
// - Only adjacent byte lanes are ever selected.
module lbm_sequencer (
	input  wire logic                clock_i,
	input  wire logic                nrst_i,
	// Core request side.
	input  wire logic                req_valid_i,
	input  wire logic                req_write_i,
	input  wire logic [29:0]         req_addr_i,
	input  wire logic [1:0]          req_size_i,
	input  wire logic [127:0]        req_wdata_i,
	input  wire logic [15:0]         req_be_i,
	output logic                     req_ready_o,
	output logic [31:0]              rdata_o,
	output logic                     rdata_valid_o,
	output logic                     done_o,
	// Local bus pins.
	input  wire logic [31:0]         shared_addr_data_lines_i,
	output logic [31:0]              shared_addr_data_lines_o,
	output logic                     shared_addr_data_lines_oe_n_o,
	output logic                     addr_latch_n_o,
	output logic                     address_state_strobe_n_o,
	output logic                     write_read_o,
	output logic                     transceiver_direction_o,
	output logic                     transceiver_output_enable_n_o,
	output logic [3:0]               byte_lane_selects_n_o,
	input  wire logic                ready_n_i,
	input  wire logic                hold_i,
	output logic                     bus_takeover_grant_o
);

	import lbm_pkg::*;

	lbm_regs_t                 r;
	lbm_regs_t                 next_r;
	logic [LBM_SYNC_W-1:0]     sync_in;
	logic [LBM_SYNC_W-1:0]     sync_rst;
	logic [LBM_SYNC_W-1:0]     sync_out;
	logic [31:0]               lad_s;
	logic                      ready_s;
	logic                      hold_s;
	logic [15:0]               be_clean;
	logic [1:0]                room;
	logic [1:0]                size_eff;
	logic [1:0]                next_idx;
	logic                      take;
	logic                      ready_new;

	// Pin inputs pass the three-stage filter; data rides with ready so
	// the sampled word lines up with the ready that qualifies it.
	assign sync_in  = {hold_i, ready_n_i, shared_addr_data_lines_i};
	assign sync_rst = {1'b0, 1'b1, LBM_LAD_RST};

	lbm_sync3 #(
		.W (LBM_SYNC_W)
	) u_pin_sync (
		.clock_i   (clock_i),
		.nrst_i    (nrst_i),
		.async_i   (sync_in),
		.rst_val_i (sync_rst),
		.sync_o    (sync_out)
	);

	// Split the filtered pins; ready is active low on the wire.
	assign lad_s   = sync_out[31:0];
	assign ready_s = ~sync_out[32];
	assign hold_s  = sync_out[33];

	// The filter drops pulses shorter than two clocks, so the responder holds
	// ready until answered; one word is taken per fresh assertion only.
	assign ready_new = ready_s && !r.ready_seen;

	generate
		for (genvar w = 0; w < LBM_WORDS; w++) begin : g_be
			lbm_be_fix u_be_fix (
				.lanes_i (req_be_i[4*w +: 4]),
				.lanes_o (be_clean[4*w +: 4])
			);
		end
	endgenerate

	// clip at block edge
	// Words left in the aligned sixteen-byte block from the start word,
	// minus one, so the burst never carries past the low word bits.
	assign room     = 2'h3 - req_addr_i[1:0];
	assign size_eff = (req_size_i > room) ? room : req_size_i;

	// A request is taken when the core offers it and the sequencer is ready.
	assign take = req_valid_i && r.req_ready;

	// Next-state logic for the whole sequencer.
	always_comb begin
		next_r             = r;
		next_r.rdata_valid = 1'b0;
		next_r.done        = 1'b0;
		next_r.ready_seen  = ready_s;
		next_idx           = r.idx + 2'h1;
		case (r.state)
			LBM_IDLE: begin
				if (r.granted) begin
					if (!hold_s) begin
						next_r.granted = 1'b0;
					end
				end else if (hold_s && !take) begin
					next_r.granted = 1'b1;
				end
			end
			// Address state ends: release the latch and status strobes and
			// turn the lines around for the first data word.
			LBM_ADDR: begin
				next_r.ale_n    = 1'b1;
				next_r.ads_n    = 1'b1;
				next_r.den_n    = 1'b0;
				next_r.lad_out  = r.wdata[31:0];
				next_r.lad_oe_n = ~r.write;
				if (ready_new) begin
					next_r.state = LBM_DATA;
				end else begin
					next_r.state = LBM_WAIT;
				end
			end
			// Data and wait states behave alike; only the name differs.
			LBM_DATA, LBM_WAIT: begin
				next_r.ads_n = 1'b1;
				if (ready_new) begin
					next_r.rdata       = lad_s;
					next_r.rdata_valid = ~r.write;
					if (r.remain == LBM_CNT_RST) begin
						next_r.state    = LBM_RECOVER;
						next_r.lad_oe_n = 1'b1;
						next_r.den_n    = 1'b1;
						next_r.be_n     = LBM_BE_IDLE;
						next_r.done     = 1'b1;
					end else begin
						next_r.state   = LBM_DATA;
						next_r.remain  = r.remain - 2'h1;
						next_r.idx     = next_idx;
						next_r.ads_n   = 1'b0;
						next_r.be_n    = ~r.be_words[4*next_idx +: 4];
						next_r.lad_out = r.wdata[32*next_idx +: 32];
					end
				end else begin
					next_r.state = LBM_WAIT;
				end
			end
			LBM_RECOVER: begin
				next_r.state = LBM_IDLE;
				next_r.dtr   = 1'b0;
				next_r.wr    = 1'b0;
				// A request taken in this clock keeps the bus; grant follows it.
				if (hold_s && !take) begin
					next_r.granted = 1'b1;
				end
			end
			default: begin
				next_r = LBM_REGS_RST;
			end
		endcase

		// start address state
		// Taken in idle or in recovery, so a pending request follows
		// the recovery clock directly.
		if (take) begin
			next_r.state    = LBM_ADDR;
			next_r.write    = req_write_i;
			next_r.wdata    = req_wdata_i;
			next_r.be_words = be_clean;
			next_r.remain   = size_eff;
			next_r.idx      = LBM_CNT_RST;
			next_r.lad_out[31:LBM_WADDR_LSB]  = req_addr_i;
			next_r.lad_out[1:LBM_SIZE_LSB]    = size_eff;
			next_r.lad_oe_n = 1'b0;
			next_r.ale_n    = 1'b0;
			next_r.ads_n    = 1'b0;
			next_r.dtr      = req_write_i;
			next_r.wr       = req_write_i;
			next_r.den_n    = 1'b1;
			next_r.be_n     = ~be_clean[3:0];
		end

		// Ready for a new request only while idle or recovering, not
		// granted away and with no hold pending.
		next_r.req_ready = ((next_r.state == LBM_IDLE) || (next_r.state == LBM_RECOVER))
			&& !next_r.granted && !hold_s;
	end

	// Register the whole state.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= LBM_REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	// Every output is a field of the registered state.
	assign req_ready_o                   = r.req_ready;
	assign rdata_o                       = r.rdata;
	assign rdata_valid_o                 = r.rdata_valid;
	assign done_o                        = r.done;
	assign shared_addr_data_lines_o      = r.lad_out;
	assign shared_addr_data_lines_oe_n_o = r.lad_oe_n;
	assign addr_latch_n_o                = r.ale_n;
	assign address_state_strobe_n_o      = r.ads_n;
	assign write_read_o                  = r.wr;
	assign transceiver_direction_o       = r.dtr;
	assign transceiver_output_enable_n_o = r.den_n;
	assign byte_lane_selects_n_o         = r.be_n;
	assign bus_takeover_grant_o          = r.granted;

endmodule

`default_nettype wire

// ### src/lbm_sync3.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes its inputs come from pins outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module lbm_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clock_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] async_i,
	input  wire logic [W-1:0] rst_val_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} lbm_sync_regs_t;

	lbm_sync_regs_t r;
	lbm_sync_regs_t next_r;
	logic           seeded;

	// Shift the chain; a bit of the output moves only when stages two and three agree.
	always_comb begin
		next_r    = r;
		next_r.s1 = async_i;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.q  = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
		if (!seeded) begin
			next_r.q = rst_val_i;
		end
	end

	// Register the state; the first clock after release seeds the output.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r      <= '0;
			seeded <= 1'b0;
		end else begin
			r      <= next_r;
			seeded <= 1'b1;
		end
	end

	assign sync_o = r.q;

endmodule

`default_nettype wire

// ### test/lbm_mem_model.sv
/* Memory controller model for the far side of the local bus.
   Assumes the bench resolves the shared lines into lad_i. */
`timescale 1ns/1ps
`default_nettype none

module lbm_mem_model (
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic [31:0] lad_i,
	input wire logic        oe_n_i,
	input wire logic        ale_n_i,
	input wire logic        ads_n_i,
	input wire logic        den_n_i,
	input wire logic        wr_i,
	input var int           lat_i,
	output logic            ready_n_o,
	output logic [31:0]     lad_o
);
	logic [31:0] mem [16];
	logic [29:0] base;
	logic        io_wr;
	int          n;
	int          k;
	int          gap;
	int          cnt;

	// I/O write command derived from write/read and transceiver enable.
	assign io_wr = wr_i & ~den_n_i;

	// Latches the address, paces the words and stores write data. Ready and
	// its word stand until the sequencer answers, then ready rests three clocks.
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ready_n_o <= 1'b1;
			lad_o <= '0;
			base <= '0;
			n <= 0;
			k <= 0;
			gap <= 0;
			cnt <= 0;
		end else begin
			if (!ale_n_i) begin
				base <= lad_i[31:2];
				n <= int'(lad_i[1:0]) + 1;
				k <= 0;
				cnt <= 0;
			end
			if (!den_n_i) cnt <= cnt + 1;
			if (!ready_n_o) begin
				if (!ads_n_i || den_n_i) begin
					ready_n_o <= 1'b1;
					k <= k + 1;
					gap <= 2;
				end
			end else if (gap > 0) begin
				gap <= gap - 1;
				lad_o <= ~lad_o;
			end else if (!den_n_i && cnt >= lat_i && k < n) begin
				ready_n_o <= 1'b0;
				lad_o <= 32'h5A00_0000 ^ {2'b00, base + 30'(k)};
				if (io_wr && !oe_n_i) mem[4'(base + 30'(k))] <= lad_i;
			end else begin
				lad_o <= ~lad_o;
			end
		end
	end
endmodule

`default_nettype wire

// ### test/lbm_seq_checker.sv
/* Port checker for the local bus sequencer.
   Assumes it is bound to lbm_sequencer, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none

module lbm_seq_checker (
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic        req_valid_i,
	input wire logic [29:0] req_addr_i,
	input wire logic        req_ready_o,
	input wire logic        done_o,
	input wire logic [31:0] shared_addr_data_lines_o,
	input wire logic        shared_addr_data_lines_oe_n_o,
	input wire logic        addr_latch_n_o,
	input wire logic        address_state_strobe_n_o,
	input wire logic        transceiver_direction_o,
	input wire logic        transceiver_output_enable_n_o,
	input wire logic [3:0]  byte_lane_selects_n_o,
	input wire logic        bus_takeover_grant_o
);
	// Short names for the watched outputs.
	wire ale_n = addr_latch_n_o;
	wire ads_n = address_state_strobe_n_o;
	wire den_n = transceiver_output_enable_n_o;
	wire oe_n  = shared_addr_data_lines_oe_n_o;
	wire dir   = transceiver_direction_o;
	wire taken = req_valid_i & req_ready_o;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// The recovery cycle: lines and transceivers released, no address.
	sequence s_rec;
		den_n && oe_n && ale_n;
	endsequence

	AST_TAKE: assert property (taken |=> !ale_n && !ads_n && !oe_n)
		else $error("no address state after take");
	AST_ADDR: assert property (taken |=> shared_addr_data_lines_o[31:2] == $past(req_addr_i))
		else $error("wrong word address");
	AST_A2D: assert property (!ale_n |=> ale_n && !den_n)
		else $error("address not followed by data or wait");
	AST_LANES: assert property (byte_lane_selects_n_o inside {4'hF, 4'hE, 4'hD, 4'hB, 4'h7,
		4'hC, 4'h9, 4'h3, 4'h8, 4'h1, 4'h0}) else $error("lanes not adjacent");
	AST_DONE: assert property (done_o |-> s_rec ##1 den_n)
		else $error("no recovery after last word");
	AST_DIR: assert property (!den_n && $past(!den_n) |-> $stable(dir))
		else $error("direction changed with transceiver on");
	AST_REL: assert property (ale_n && den_n |-> oe_n)
		else $error("lines driven outside address and data");
	AST_ADS: assert property (!ads_n |-> !ale_n || !den_n)
		else $error("strobe outside address, data or wait");
	AST_GRANT: assert property (bus_takeover_grant_o |-> s_rec)
		else $error("bus driven while granted");
endmodule

bind lbm_sequencer lbm_seq_checker lbm_seq_checker_i (.*);

`default_nettype wire

// ### test/lbm_sequencer_tb.sv
/* Self-checking bench for the local bus sequencer.
   Assumes the memory model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none

module lbm_sequencer_tb;
	logic         clock_i, nrst_i, req_valid, req_write, hold, ready_n;
	logic         req_ready, rvalid, done, oe_n, ale_n, ads_n, wr, den_n, grant;
	logic [29:0]  req_addr;
	logic [1:0]   req_size;
	logic [127:0] wdata;
	logic [15:0]  be;
	logic [31:0]  lad_o, rdata, mdl_lad;
	logic [3:0]   lanes_n;
	int           lat, bad_count, n_compared;
	wire logic [31:0] bus = oe_n ? mdl_lad : lad_o;

	lbm_sequencer lbm_sequencer_i (.clock_i(clock_i), .nrst_i(nrst_i),
		.req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
		.req_size_i(req_size), .req_wdata_i(wdata), .req_be_i(be), .req_ready_o(req_ready),
		.rdata_o(rdata), .rdata_valid_o(rvalid), .done_o(done),
		.shared_addr_data_lines_i(bus), .shared_addr_data_lines_o(lad_o),
		.shared_addr_data_lines_oe_n_o(oe_n), .addr_latch_n_o(ale_n),
		.address_state_strobe_n_o(ads_n), .write_read_o(wr), .transceiver_direction_o(),
		.transceiver_output_enable_n_o(den_n), .byte_lane_selects_n_o(lanes_n),
		.ready_n_i(ready_n), .hold_i(hold), .bus_takeover_grant_o(grant));

	lbm_mem_model lbm_mem_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .lad_i(bus),
		.oe_n_i(oe_n), .ale_n_i(ale_n), .ads_n_i(ads_n), .den_n_i(den_n), .wr_i(wr), .lat_i(lat),
		.ready_n_o(ready_n), .lad_o(mdl_lad));

	// Free-running 20 MHz clock.
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task summarize;
		$display("bad_count=%0d n_compared=%0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task take;
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge clock_i);
			if (req_ready === 1'b1) break;
		end
		if (i == 50) begin
			check(1, 0, "request not taken");
			summarize();
		end
	endtask

	task wait_done;
		int i;
		for (i = 0; i < 400 && done !== 1'b1; i++) begin
			@(posedge clock_i);
			#1;
		end
		if (done !== 1'b1) begin
			check(1, 0, "transfer hangs");
			summarize();
		end
	endtask

	// One transfer with address, word count and data checks.
	task run(input logic w, input logic [29:0] a, input logic [1:0] s, input int l,
		input logic [3:0] exl);
		int i, k, n;
		n = (s > 2'd3 - a[1:0]) ? 4 - a[1:0] : s + 1;
		@(posedge clock_i);
		lat <= l;
		req_write <= w;
		req_addr <= a;
		req_size <= s;
		wdata <= {2'b11, a + 30'd3, 2'b11, a + 30'd2, 2'b11, a + 30'd1, 2'b11, a};
		req_valid <= 1'b1;
		take();
		req_valid <= 1'b0;
		#1;
		check(lad_o, {a, 2'(n - 1)}, "address word");
		check(lanes_n, exl, "first lanes");
		check(wr, w, "command");
		k = 0;
		for (i = 0; i < 400 && done !== 1'b1; i++) begin
			@(posedge clock_i);
			#1;
			if (rvalid === 1'b1) begin
				check(rdata, 32'h5A00_0000 ^ {2'b00, a + 30'(k)}, "read word");
				k++;
			end
		end
		check(32'(k), w ? 0 : 32'(n), "word count");
		for (i = 0; i < n && w; i++)
			check(lbm_mem_model_i.mem[4'(a + 30'(i))], wdata[32*i +: 32], "write word");
		if (done !== 1'b1) begin
			check(1, 0, "transfer hangs");
			summarize();
		end
	endtask

	// A pending request starts right after recovery.
	task b2b;
		@(posedge clock_i);
		lat <= 0;
		req_write <= 1'b0;
		req_size <= 2'd0;
		req_addr <= 30'h200;
		req_valid <= 1'b1;
		take();
		req_addr <= 30'h201;
		wait_done();
		@(posedge clock_i);
		req_valid <= 1'b0;
		#1;
		check(ale_n, 0, "gap after recovery");
		wait_done();
	endtask

	// Hold is granted in idle and refuses requests.
	task hold_test;
		int i;
		@(posedge clock_i);
		hold <= 1'b1;
		for (i = 0; i < 20 && grant !== 1'b1; i++) @(posedge clock_i);
		#1;
		check(grant, 1, "no grant");
		check(req_ready, 0, "taking while granted");
		@(posedge clock_i);
		hold <= 1'b0;
		for (i = 0; i < 20 && grant !== 1'b0; i++) @(posedge clock_i);
		#1;
		check(grant, 0, "grant kept");
	endtask

	// Reset, then the scenarios in turn.
	initial begin
		{nrst_i, req_valid, req_write, hold, req_addr, req_size, wdata} = '0;
		be = 16'hFFFF;
		lat = 0;
		bad_count = 0;
		n_compared = 0;
		repeat (16) @(posedge clock_i);
		check(lanes_n, 4'hF, "reset lanes");
		check(oe_n, 1, "reset lines");
		nrst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		for (int s = 0; s < 4; s++) begin
			run(0, 30'h100, 2'(s), 0, 4'h0);
			run(1, 30'h110 + 30'(s * 4), 2'(s), 4, 4'h0);
		end
		run(0, 30'h123, 2'd3, 20, 4'h0);
		run(0, 30'h22, 2'd3, 2, 4'h0);
		be <= 16'h0005;
		run(1, 30'h140, 2'd0, 1, 4'h8);
		be <= 16'hFFFF;
		b2b();
		hold_test();
		summarize();
	end
endmodule

`default_nettype wire
